// ==== logic/hgt_defs.svh ====
`ifndef HGT_DEFS_SVH
`define HGT_DEFS_SVH
`define HGT_CTRL_ADDR 16'h0455
`define HGT_ARM_BIT 7
`define HGT_CTRL_RESET 8'h00
`define HGT_CLK_HZ 50000000
`define HGT_TIMEOUT_MS 1100
`define HGT_TICK_US 1000
`define HGT_PRESCALE (`HGT_CLK_HZ / 1000000 * `HGT_TICK_US)
`define HGT_TIMEOUT_TICKS (`HGT_TIMEOUT_MS * 1000 / `HGT_TICK_US)
`define HGT_RESET_PULSE_CYCLES 16
`endif

// ==== logic/hgt_pkg.sv ====
package hgt_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } hgt_io_req_t;
  typedef enum logic [2:0] {
    HGT_IDLE = 3'b001,
    HGT_ARMED = 3'b010,
    HGT_FIRE = 3'b100
  } hgt_state_t;
endpackage

// ==== logic/hgt_watchdog.sv ====
`timescale 1ns/1ns
`include "hgt_defs.svh"
module hgt_watchdog #(
  parameter int unsigned PRESCALE = `HGT_PRESCALE,
  parameter int unsigned TIMEOUT_TICKS = `HGT_TIMEOUT_TICKS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic fw_enable,
  input wire hgt_pkg::hgt_io_req_t io_req,
  output logic io_hit,
  output logic [7:0] io_rdata,
  output logic board_reset
);
  // Terminal counts, cut to the counter widths on purpose
  localparam logic [4:0] PULSE_LAST = 5'(`HGT_RESET_PULSE_CYCLES - 1);
  localparam logic [15:0] PRE_LAST = 16'(PRESCALE - 1);
  localparam logic [11:0] TICK_LAST = 12'(TIMEOUT_TICKS - 1);

  // Register decode, used by the strobes and by io_hit
  function automatic logic ctrl_sel(input logic enable, input logic [15:0] addr);
    return enable && (addr == `HGT_CTRL_ADDR);
  endfunction

  function automatic logic ctrl_read(input logic hit, input hgt_pkg::hgt_io_req_t req);
    return hit && req.rd;
  endfunction

  function automatic logic ctrl_write(input logic hit, input hgt_pkg::hgt_io_req_t req);
    return hit && req.wr;
  endfunction

  // Registered state and next values
  hgt_pkg::hgt_state_t state_reg;
  hgt_pkg::hgt_state_t state_next;
  logic [15:0] pre_reg;
  logic [15:0] pre_next;
  logic [11:0] tick_reg;
  logic [11:0] tick_next;
  logic [4:0] pulse_reg;
  logic [4:0] pulse_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic sel;
  logic rd_hit;
  logic wr_hit;
  logic arm_req;
  logic disarm_req;
  logic armed;
  logic firing;
  logic restart;
  logic pre_wrap;
  logic expire;

  // Strobes decoded from the current request
  assign sel = ctrl_sel(fw_enable, io_req.addr);
  assign rd_hit = ctrl_read(sel, io_req);
  assign wr_hit = ctrl_write(sel, io_req);
  assign arm_req = wr_hit && io_req.wdata[`HGT_ARM_BIT];
  assign disarm_req = wr_hit && !io_req.wdata[`HGT_ARM_BIT];
  assign io_hit = rd_hit || wr_hit;
  assign armed = (state_reg == hgt_pkg::HGT_ARMED);
  assign firing = (state_reg == hgt_pkg::HGT_FIRE);
  // Counters sit at zero unless armed and enabled; a read or a disarm write restarts them, an arm write does not
  assign restart = !armed || !fw_enable || rd_hit || disarm_req;
  assign pre_wrap = (pre_reg == PRE_LAST);
  assign expire = pre_wrap && (tick_reg == TICK_LAST) && !restart;
  assign io_rdata = rdata_reg;
  assign board_reset = firing;

  // Arm state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      hgt_pkg::HGT_IDLE:
      begin
        if (arm_req)
        begin
          state_next = hgt_pkg::HGT_ARMED;
        end
      end
      hgt_pkg::HGT_ARMED:
      begin
        // A disarm or firmware disable wins over expiry in the same cycle
        if (!fw_enable || disarm_req)
        begin
          state_next = hgt_pkg::HGT_IDLE;
        end
        else if (expire)
        begin
          state_next = hgt_pkg::HGT_FIRE;
        end
      end
      hgt_pkg::HGT_FIRE:
      begin
        // The pulse ends disarmed; a firmware disable cuts it short
        if (!fw_enable || (pulse_reg == PULSE_LAST))
        begin
          state_next = hgt_pkg::HGT_IDLE;
        end
      end
      default:
      begin
        state_next = hgt_pkg::HGT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= hgt_pkg::HGT_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Board clock to one-tick prescaler, wrapping once per tick while armed
  always_comb
  begin
    if (restart || pre_wrap)
    begin
      pre_next = 16'h0000;
    end
    else
    begin
      pre_next = pre_reg + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_reg <= 16'h0000;
    end
    else
    begin
      pre_reg <= pre_next;
    end
  end

  // Tick counter toward expiry
  always_comb
  begin
    tick_next = tick_reg;
    if (restart || expire)
    begin
      tick_next = 12'h000;
    end
    else if (pre_wrap)
    begin
      tick_next = tick_reg + 12'h001;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_reg <= 12'h000;
    end
    else
    begin
      tick_reg <= tick_next;
    end
  end

  // Length of the board reset pulse
  always_comb
  begin
    if (firing)
    begin
      pulse_next = pulse_reg + 5'h01;
    end
    else
    begin
      pulse_next = 5'h00;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pulse_reg <= 5'h00;
    end
    else
    begin
      pulse_reg <= pulse_next;
    end
  end

  // Read data: arm state in the top bit, reserved bits read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    // Reads during the pulse return zero, as the block is no longer armed
    if (rd_hit)
    begin
      rdata_next = {armed, 7'h00};
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_reg <= `HGT_CTRL_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end
endmodule // hgt_watchdog

// ==== verification/hgt_chk.sv ====
`timescale 1ns/1ns
module hgt_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic fw_enable,
  input wire hgt_pkg::hgt_io_req_t io_req,
  input wire logic io_hit,
  input wire logic [7:0] io_rdata,
  input wire logic board_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_HIT: assert property (io_hit == (fw_enable && io_req.addr == 16'h0455 &&
    (io_req.rd || io_req.wr))) else $error("hit");
  AST_RSV: assert property (io_hit && io_req.rd |=> io_rdata[6:0] == 7'h00) else $error("rsv");
  AST_PULSE: assert property ($rose(board_reset) |-> board_reset [*8]) else $error("pulse");
  AST_DIS: assert property (io_hit && io_req.wr && !io_req.wdata[7] && !board_reset
    |=> !board_reset [*8]) else $error("dis");
  AST_REF: assert property (io_hit && io_req.rd && !board_reset |=> !board_reset [*8])
    else $error("ref");
  logic [4:0] run_cnt;
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_cnt <= 5'h00;
    end
    else if (board_reset)
    begin
      run_cnt <= run_cnt + 5'h01;
    end
    else
    begin
      run_cnt <= 5'h00;
    end
  end
  AST_PULSE_LEN: assert property ($fell(board_reset) && $past(fw_enable) |-> run_cnt == 5'h10)
    else $error("pulse length");
  AST_FWOFF: assert property (!fw_enable |=> !board_reset) else $error("fwoff");
endmodule // hgt_chk
bind hgt_watchdog hgt_chk hgt_chk_inst (.clock, .sys_rst, .fw_enable, .io_req, .io_hit,
  .io_rdata, .board_reset);

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic fw_enable = 1'b1;
  hgt_pkg::hgt_io_req_t io_req = '0;
  logic io_hit;
  logic [7:0] io_rdata;
  logic board_reset;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  logic hit_seen;
  logic [7:0] rows [3][2] = '{'{8'hFF, 8'h80}, '{8'h7F, 8'h00}, '{8'h80, 8'h80}};
  always #10 clock = ~clock;
  hgt_watchdog #(.PRESCALE(4), .TIMEOUT_TICKS(5)) hgt_watchdog_inst (.clock, .sys_rst,
    .fw_enable, .io_req, .io_hit, .io_rdata, .board_reset);
  task automatic acc(input logic rd, input logic [7:0] d);
    @(posedge clock) io_req <= '{16'h0455, d, rd, !rd};
    #1 hit_seen = io_hit;
    @(posedge clock) io_req <= '0;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk("rst", 8'h00, io_rdata);
    foreach (rows[i])
    begin
      acc(1'b0, rows[i][0]);
      chk("hit", 8'h01, {7'h00, hit_seen});
      acc(1'b1, 8'h00);
      #1 chk("ctrl", rows[i][1], io_rdata);
    end
    repeat (12) acc(1'b1, 8'h00);
    #1 chk("refresh", 8'h00, {7'h00, board_reset});
    for (n = 0; n < 40 && board_reset !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk("expiry", 8'h14, 8'(n));
    for (n = 0; n < 40 && board_reset === 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk("pulse", 8'h10, 8'(n));
    acc(1'b1, 8'h00);
    #1 chk("disarmed", 8'h00, io_rdata);
    repeat (20) @(posedge clock);
    fw_enable <= 1'b0;
    acc(1'b0, 8'h80);
    chk("fwhit", 8'h00, {7'h00, hit_seen});
    repeat (30) @(posedge clock);
    #1 chk("fwoff", 8'h00, {7'h00, board_reset});
    @(posedge clock) fw_enable <= 1'b1;
    acc(1'b1, 8'h00);
    #1 acc(1'b0, {1'b1, io_rdata[6:0]});
    @(posedge clock) sys_rst <= 1'b1;
    @(posedge clock) sys_rst <= 1'b0;
    acc(1'b1, 8'h00);
    #1 chk("rst2", 8'h00, io_rdata);
    conclude;
  end
  initial
  begin
    #10000;
    mismatches++;
    conclude;
  end
endmodule // tb
